// file: sim/dsfm_assertions.sv
// port checker of the fault monitor
`timescale 1ns/100ps
module dsfm_assertions #(
  parameter int STO_DIFF_CYCLES = 20
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic safe_torque_off_input_a_n,
  input wire logic safe_torque_off_input_b_n,
  input wire logic operation_enabled,
  input wire logic pti_freq_over_limit,
  input wire logic fault_reset,
  input wire logic func_assign_req,
  input wire logic func_usable_in_mode,
  input wire logic request_refused,
  input wire logic [31:0] latched_signal_status,
  input wire logic [31:0] latched_warning_status
);
  // ********************************************************************
  // pin aliases and discrepancy counter
  // ********************************************************************
  wire logic sa = safe_torque_off_input_a_n;
  wire logic sb = safe_torque_off_input_b_n;
  wire logic [31:0] sg = latched_signal_status;
  logic [31:0] dcnt_r;
  logic [31:0] dcnt_nxt;
  // counts cycles with the two pins apart
  assign dcnt_nxt = (sa == sb) ? 32'h0 : dcnt_r + 32'h1;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) dcnt_r <= 32'h0;
    else dcnt_r <= dcnt_nxt;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  a_sto_in_op: assert property ($past(sa & sb) && !(sa & sb)
    && operation_enabled |-> ##[3:4] sg[10])
    else $error("sto in operation not latched");
  a_sto_warn: assert property ($past(sa & sb) && !(sa & sb)
    && !operation_enabled |-> ##[3:4] latched_warning_status[10])
    else $error("sto warning not latched");
  a_warn_clear: assert property ((sa & sb) [*4] |=>
    !latched_warning_status[10]) else $error("sto warning stays set");
  a_diff_late: assert property (
    dcnt_r == STO_DIFF_CYCLES + 6 |-> sg[11])
    else $error("discrepancy not latched");
  a_diff_early: assert property (
    $rose(sg[11]) |-> dcnt_r >= STO_DIFF_CYCLES + 2)
    else $error("discrepancy latched too early");
  a_freq_latch: assert property (
    pti_freq_over_limit |-> ##[3:4] sg[28])
    else $error("frequency fault not latched");
  a_sig_sticky: assert property (!$past(fault_reset) |->
    ($past(sg) & ~sg) == 32'h0) else $error("signal bit dropped");
  a_fault_clear: assert property (
    (sa && sb && !pti_freq_over_limit) [*4] ##0 fault_reset
    |=> sg == 32'h0) else $error("fault reset left bits set");
  a_func_refuse: assert property (
    func_assign_req && !func_usable_in_mode |=> request_refused)
    else $error("function request not refused");
  c_diff: cover property ($rose(sg[11]));
  c_warn: cover property ($rose(latched_warning_status[10]));
  c_refuse: cover property (func_assign_req ##1 request_refused);
endmodule : dsfm_assertions
bind dsfm_monitor dsfm_assertions #(.STO_DIFF_CYCLES(STO_DIFF_CYCLES)) u_chk (
  .clock, .rstn, .safe_torque_off_input_a_n, .safe_torque_off_input_b_n,
  .operation_enabled, .pti_freq_over_limit, .fault_reset, .func_assign_req,
  .func_usable_in_mode, .request_refused, .latched_signal_status,
  .latched_warning_status);

// file: sim/dsfm_monitor_tb.sv
// self-checking bench of the fault monitor
`timescale 1ns/100ps
module dsfm_monitor_tb;
  localparam int DIFF = 20;
  localparam logic [15:0] CODE [7] = '{16'h112A, 16'h112E, 16'h0000,
    16'h0000, 16'h1311, 16'h1312, 16'h1313};
  logic clock = 1'b0, rstn = 1'b0, op = 1'b0;
  logic usable = 1'b0, limits = 1'b0, dbs = 1'b0;
  logic sa_on = 1'b0, sb_on = 1'b0, fast = 1'b0;
  logic [8:0] rq = '0;
  logic [1:0] esel = '0, eset = '0, copen = '0, cclose = '0;
  logic sa_n, sb_n, pti, acc, rfs, dact, dbe, ev;
  logic [1:0] crf, cgr, ce1, ce2;
  logic [31:0] sig, wrn;
  dsfm_pkg::dsfm_err_t err;
  dsfm_pkg::dsfm_class_t cls;
  int mismatches = 0, tests_run = 0, seed = 32'h66e9;
  int probed = 0, e1 = 0, e2 = 0, act = 0;
  // ********************************************************************
  // clock, far side and design
  // ********************************************************************
  initial begin
    forever #5 clock = ~clock;
  end
  dsfm_wiring u_wire (.safe_torque_off_input_a_on(sa_on), .safe_torque_off_input_b_on(sb_on), .pulse_fast(fast),
    .safe_torque_off_input_a_n(sa_n), .safe_torque_off_input_b_n(sb_n),
    .pti_freq_over_limit(pti));
  dsfm_monitor #(.STO_DIFF_CYCLES(DIFF), .CHANNELS(2)) dut (
    .clock, .rstn, .safe_torque_off_input_a_n(sa_n),
    .safe_torque_off_input_b_n(sb_n), .operation_enabled(op),
    .pti_freq_over_limit(pti), .capture_enable_req(rq[0]),
    .edge_set_req(rq[1]), .diff_cfg_req(rq[2]), .diff_capture_stop(rq[3]),
    .func_assign_req(rq[4]), .ref_move_req(rq[5]), .debounce_req(rq[6]),
    .probing_cycle_command(rq[7]), .fault_reset(rq[8]),
    .edge_set_input(esel), .capture_edge_setting(eset),
    .func_usable_in_mode(usable), .limits_assigned(limits),
    .debounce_supported(dbs), .cfg_open_req(copen), .cfg_close_req(cclose),
    .latched_signal_status(sig), .latched_warning_status(wrn),
    .error_number(err), .error_class(cls), .error_valid(ev),
    .cfg_refused(crf), .cfg_granted(cgr), .request_accepted(acc),
    .request_refused(rfs), .diff_capture_active(dact),
    .debounce_error(dbe), .capture_edge_1(ce1), .capture_edge_2(ce2));
  // compares one value and counts it
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test;
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  // one request pulse, answer compared with the reference model
  task automatic step(input int k);
    logic rf;
    case (k)
      0: rf = !probed;
      1: rf = act;
      2: rf = (e1 != 3) || (e2 != 3);
      4: rf = !usable;
      5: rf = !limits;
      6: rf = !dbs;
      default: rf = 1'b0;
    endcase
    @(negedge clock); // idle cycle keeps back to back pulses apart
    rq[k] = 1'b1;
    @(negedge clock);
    rq[k] = 1'b0;
    if (k < 7 && k != 3) chk(rfs, rf);
    chk({acc, ev}, {k < 7 && k != 3 && !rf, rf});
    if (k != 2 && rf) chk(err, CODE[k]);
    if (k == 2 && rf) chk(err, (e1 != 3) ? 16'h112B : 16'h112C);
    if (k == 6) chk(dbe, rf);
    if (k == 1 && !rf && !esel[1]) e1 = eset;
    if (k == 1 && !rf && esel[1]) e2 = eset;
    if (k == 2 && !rf) act = 1;
    if (k == 3) act = 0;
    if (k == 7) probed = 1;
    chk({ce1, ce2, dact}, {e1[1:0], e2[1:0], act[0]});
  endtask : step
  task automatic pins(input logic a, input logic b, input logic f);
    sa_on = a;
    sb_on = b;
    fast = f;
    repeat (6) @(negedge clock);
  endtask : pins
  task automatic cpulse(input logic [1:0] o, input logic [1:0] c);
    @(negedge clock); // idle cycle keeps back to back pulses apart
    copen = o;
    cclose = c;
    @(negedge clock);
    copen = '0;
    cclose = '0;
  endtask : cpulse
  // ********************************************************************
  // main sequence
  // ********************************************************************
  initial begin
    repeat (16) @(negedge clock);
    chk(cls, 3'h7);
    rstn = 1'b1;
    step(0);
    step(7);
    step(2);
    eset = 2'h3;
    step(1);
    step(2);
    esel = 2'h2;
    step(1);
    step(2);
    step(1);
    step(3);
    repeat (80) begin
      esel = $random(seed);
      eset = $random(seed);
      {usable, limits, dbs} = $random(seed);
      step({$random(seed)} % 8);
    end
    cpulse(2'b01, 2'b00);
    chk(cgr, 2'b01);
    cpulse(2'b10, 2'b00);
    chk({crf, cgr, err}, {2'b10, 2'b01, 16'h1126});
    cpulse(2'b00, 2'b01);
    cpulse(2'b11, 2'b00);
    chk({crf, cgr}, {2'b10, 2'b01});
    pins(1'b1, 1'b1, 1'b0);
    chk({wrn, sig}, {32'h400, 32'h0});
    chk({err, 13'h0, cls}, {16'h1302, 16'h0});
    pins(1'b0, 1'b0, 1'b0);
    chk(wrn, 32'h0);
    op = 1'b1;
    pins(1'b1, 1'b1, 1'b0);
    chk({err, 13'h0, cls}, {16'h1300, 13'h0, 3'h3});
    pins(1'b0, 1'b0, 1'b0);
    chk(sig, 32'h400);
    step(8);
    chk(sig, 32'h0);
    op = 1'b0;
    sa_on = 1'b1;
    repeat (DIFF - 4) @(negedge clock);
    chk(sig[11], 1'b0);
    repeat (12) @(negedge clock);
    chk({err, 13'h0, cls, sig}, {16'h1301, 16'h4, 32'h800});
    pins(1'b0, 1'b0, 1'b0);
    step(8);
    pins(1'b0, 1'b0, 1'b1);
    pins(1'b0, 1'b0, 1'b0);
    chk(sig, 32'h1000_0000);
    chk({err, 13'h0, cls}, {16'h1310, 13'h0, 3'h2});
    finish_test();
  end
endmodule : dsfm_monitor_tb

// file: sim/dsfm_wiring.sv
// far side model: safety wiring and reference pulse source
`timescale 1ns/100ps
module dsfm_wiring (
  input wire logic safe_torque_off_input_a_on,
  input wire logic safe_torque_off_input_b_on,
  input wire logic pulse_fast,
  output logic safe_torque_off_input_a_n,
  output logic safe_torque_off_input_b_n,
  output logic pti_freq_over_limit
);
  // an active channel opens its contact, so the pin reads low
  assign safe_torque_off_input_a_n = !safe_torque_off_input_a_on;
  assign safe_torque_off_input_b_n = !safe_torque_off_input_b_on;
  assign pti_freq_over_limit = pulse_fast; // pulse rate above the limit
endmodule : dsfm_wiring

// file: src/dsfm_map.svh
// bit positions, error classes, error codes and timing counts of the fault monitor
`ifndef DSFM_MAP_SVH
`define DSFM_MAP_SVH
// ********************************************************************
// status word bits
// ********************************************************************
`define DSFM_SIG_BIT_STO_OPEN 10
`define DSFM_SIG_BIT_STO_DIFF 11
`define DSFM_SIG_BIT_PTI_FREQ 28
`define DSFM_WARN_BIT_STO 10
`define DSFM_STATUS_RESET 32'h0000_0000
// ********************************************************************
// error classes
// ********************************************************************
`define DSFM_CLASS_NONE 3'h7
`define DSFM_CLASS_STO_DIFF 3'h4
`define DSFM_CLASS_STO_OPEN 3'h3
`define DSFM_CLASS_PTI_FREQ 3'h2
`define DSFM_CLASS_STO_WARN 3'h0
// ********************************************************************
// error numbers
// ********************************************************************
`define DSFM_ERR_NONE 16'h0000
`define DSFM_ERR_CFG_BLOCKED 16'h1126
`define DSFM_ERR_CAP_NOT_ACT 16'h112A
`define DSFM_ERR_DIFF_EDGE1 16'h112B
`define DSFM_ERR_DIFF_EDGE2 16'h112C
`define DSFM_ERR_EDGE_LOCKED 16'h112E
`define DSFM_ERR_STO_OPEN 16'h1300
`define DSFM_ERR_STO_DIFF 16'h1301
`define DSFM_ERR_STO_WARN 16'h1302
`define DSFM_ERR_PTI_FREQ 16'h1310
`define DSFM_ERR_FUNC_MODE 16'h1311
`define DSFM_ERR_NO_LIMITS 16'h1312
`define DSFM_ERR_DEBOUNCE 16'h1313
// ********************************************************************
// timing and capture edge setting
// ********************************************************************
`define DSFM_CLK_HZ 100000000
`define DSFM_STO_DIFF_MS 1000
`define DSFM_STO_DIFF_CYC ((`DSFM_CLK_HZ / 1000) * `DSFM_STO_DIFF_MS)
`define DSFM_EDGE_BOTH 2'h3
`endif

// file: src/dsfm_monitor.sv
// safe torque off, reference frequency and configuration fault monitor
`include "dsfm_map.svh"
`timescale 1ns/100ps
module dsfm_monitor #(
  parameter int STO_DIFF_CYCLES = `DSFM_STO_DIFF_CYC,
  parameter int CHANNELS = 2
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic safe_torque_off_input_a_n,
  input wire logic safe_torque_off_input_b_n,
  input wire logic operation_enabled,
  input wire logic pti_freq_over_limit,
  input wire logic fault_reset,
  input wire logic probing_cycle_command,
  input wire logic capture_enable_req,
  input wire logic edge_set_req,
  input wire logic [1:0] edge_set_input,
  input wire logic [1:0] capture_edge_setting,
  input wire logic diff_cfg_req,
  input wire logic diff_capture_stop,
  input wire logic func_assign_req,
  input wire logic func_usable_in_mode,
  input wire logic ref_move_req,
  input wire logic limits_assigned,
  input wire logic debounce_req,
  input wire logic debounce_supported,
  input wire logic [CHANNELS-1:0] cfg_open_req,
  input wire logic [CHANNELS-1:0] cfg_close_req,
  output logic [31:0] latched_signal_status,
  output logic [31:0] latched_warning_status,
  output dsfm_pkg::dsfm_err_t error_number,
  output dsfm_pkg::dsfm_class_t error_class,
  output logic error_valid,
  output logic [CHANNELS-1:0] cfg_refused,
  output logic [CHANNELS-1:0] cfg_granted,
  output logic request_accepted,
  output logic request_refused,
  output logic diff_capture_active,
  output logic debounce_error,
  output logic [1:0] capture_edge_1,
  output logic [1:0] capture_edge_2
);
  // ******************************************************************
  // pin synchronisation
  // ******************************************************************
  logic [2:0] pin_sync;
  dsfm_sync #(.WIDTH(3)) u_sync (
    .clock(clock),
    .rstn(rstn),
    .async_in({pti_freq_over_limit, safe_torque_off_input_b_n,
      safe_torque_off_input_a_n}),
    .sync_out(pin_sync)
  );
  wire safe_torque_off_input_a_active = ~pin_sync[0];
  wire safe_torque_off_input_b_active = ~pin_sync[1];
  wire pti_over = pin_sync[2];
  wire safe_torque_off = safe_torque_off_input_a_active | safe_torque_off_input_b_active;
  wire sto_differ = safe_torque_off_input_a_active ^ safe_torque_off_input_b_active;

  // ******************************************************************
  // sto discrepancy and activation
  // ******************************************************************
  logic [31:0] diff_cnt_r;
  logic sto_prev_r;
  logic [31:0] diff_lim;
  assign diff_lim = 32'(STO_DIFF_CYCLES);
  wire diff_expire = sto_differ && (diff_cnt_r == diff_lim);
  wire sto_rise = safe_torque_off && !sto_prev_r;
  wire sto_err_evt = sto_rise && operation_enabled;
  wire sto_warn_evt = sto_rise && !operation_enabled;
  wire pti_evt = pti_over;

  // discrepancy timer, counts while channels differ
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      diff_cnt_r <= 32'h0000_0000;
      sto_prev_r <= 1'b1; // synced pins read active in reset, no false rise
    end else begin
      sto_prev_r <= safe_torque_off;
      if (!sto_differ)
        diff_cnt_r <= 32'h0000_0000;
      else if (diff_cnt_r <= diff_lim)
        diff_cnt_r <= diff_cnt_r + 32'h0000_0001;
    end
  end

  // ******************************************************************
  // latched status words
  // ******************************************************************
  logic [31:0] sig_set;
  logic [31:0] warn_nxt;
  always_comb begin
    sig_set = 32'h0000_0000;
    sig_set[`DSFM_SIG_BIT_STO_DIFF] = diff_expire;
    sig_set[`DSFM_SIG_BIT_STO_OPEN] = sto_err_evt;
    sig_set[`DSFM_SIG_BIT_PTI_FREQ] = pti_evt;
    warn_nxt = latched_warning_status;
    if (!safe_torque_off)
      warn_nxt[`DSFM_WARN_BIT_STO] = 1'b0;
    if (sto_warn_evt)
      warn_nxt[`DSFM_WARN_BIT_STO] = 1'b1;
  end

  // set wins over fault reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      latched_signal_status <= `DSFM_STATUS_RESET;
      latched_warning_status <= `DSFM_STATUS_RESET;
    end else begin
      latched_signal_status <= (fault_reset ? 32'h0000_0000 :
        latched_signal_status) | sig_set;
      latched_warning_status <= warn_nxt;
    end
  end

  // ******************************************************************
  // configuration channel ownership
  // ******************************************************************
  logic cfg_held_r;
  logic [CHANNELS-1:0] owner_r;
  logic [CHANNELS-1:0] grant_pick;
  always_comb begin
    grant_pick = '0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (cfg_open_req[i])
        grant_pick = CHANNELS'(1) << i;
    end
  end
  wire [CHANNELS-1:0] refuse_now = cfg_held_r ? (cfg_open_req & ~owner_r)
    : (cfg_open_req & ~grant_pick);
  wire owner_close = |(cfg_close_req & owner_r);

  // ownership register, lowest channel wins a tie
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_held_r <= 1'b0;
      owner_r <= '0;
      cfg_refused <= '0;
    end else begin
      cfg_refused <= refuse_now;
      if (cfg_held_r && owner_close) begin
        cfg_held_r <= 1'b0;
        owner_r <= '0;
      end else if (!cfg_held_r && |cfg_open_req) begin
        cfg_held_r <= 1'b1;
        owner_r <= grant_pick;
      end
    end
  end
  assign cfg_granted = owner_r;

  // ******************************************************************
  // capture and function request checks
  // ******************************************************************
  logic probing_r;
  logic [15:0] err_pick;
  logic [2:0] cls_pick;
  wire edge1_both = capture_edge_1 == `DSFM_EDGE_BOTH;
  wire edge2_both = capture_edge_2 == `DSFM_EDGE_BOTH;
  wire cap_bad = capture_enable_req && !probing_r;
  wire edge_bad = edge_set_req && diff_capture_active;
  wire diff_bad1 = diff_cfg_req && !edge1_both;
  wire diff_bad2 = diff_cfg_req && edge1_both && !edge2_both;
  wire func_bad = func_assign_req && !func_usable_in_mode;
  wire ref_bad = ref_move_req && !limits_assigned;
  wire deb_bad = debounce_req && !debounce_supported;
  wire any_req = capture_enable_req | edge_set_req | diff_cfg_req |
    func_assign_req | ref_move_req | debounce_req;
  wire any_bad = cap_bad | edge_bad | diff_bad1 | diff_bad2 | func_bad |
    ref_bad | deb_bad;

  // error selection, most severe first
  always_comb begin
    err_pick = `DSFM_ERR_NONE;
    cls_pick = `DSFM_CLASS_NONE;
    if (diff_expire) begin
      err_pick = `DSFM_ERR_STO_DIFF;
      cls_pick = `DSFM_CLASS_STO_DIFF;
    end else if (sto_err_evt) begin
      err_pick = `DSFM_ERR_STO_OPEN;
      cls_pick = `DSFM_CLASS_STO_OPEN;
    end else if (pti_evt) begin
      err_pick = `DSFM_ERR_PTI_FREQ;
      cls_pick = `DSFM_CLASS_PTI_FREQ;
    end else if (sto_warn_evt) begin
      err_pick = `DSFM_ERR_STO_WARN;
      cls_pick = `DSFM_CLASS_STO_WARN;
    end else if (|refuse_now)
      err_pick = `DSFM_ERR_CFG_BLOCKED;
    else if (cap_bad)
      err_pick = `DSFM_ERR_CAP_NOT_ACT;
    else if (edge_bad)
      err_pick = `DSFM_ERR_EDGE_LOCKED;
    else if (diff_bad1)
      err_pick = `DSFM_ERR_DIFF_EDGE1;
    else if (diff_bad2)
      err_pick = `DSFM_ERR_DIFF_EDGE2;
    else if (func_bad)
      err_pick = `DSFM_ERR_FUNC_MODE;
    else if (ref_bad)
      err_pick = `DSFM_ERR_NO_LIMITS;
    else if (deb_bad)
      err_pick = `DSFM_ERR_DEBOUNCE;
  end

  // capture state, edge settings and error report
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      probing_r <= 1'b0;
      diff_capture_active <= 1'b0;
      capture_edge_1 <= 2'h0;
      capture_edge_2 <= 2'h0;
      debounce_error <= 1'b0;
      error_number <= `DSFM_ERR_NONE;
      error_class <= `DSFM_CLASS_NONE;
      error_valid <= 1'b0;
      request_accepted <= 1'b0;
      request_refused <= 1'b0;
    end else begin
      if (probing_cycle_command)
        probing_r <= 1'b1;
      if (edge_set_req && !edge_bad && !edge_set_input[1])
        capture_edge_1 <= capture_edge_setting;
      if (edge_set_req && !edge_bad && edge_set_input[1])
        capture_edge_2 <= capture_edge_setting;
      if (diff_capture_stop)
        diff_capture_active <= 1'b0;
      else if (diff_cfg_req && !diff_bad1 && !diff_bad2)
        diff_capture_active <= 1'b1;
      if (debounce_req)
        debounce_error <= deb_bad;
      error_valid <= err_pick != `DSFM_ERR_NONE;
      if (err_pick != `DSFM_ERR_NONE) begin
        error_number <= err_pick;
        error_class <= cls_pick;
      end
      request_accepted <= any_req && !any_bad;
      request_refused <= any_req && any_bad;
    end
  end
endmodule : dsfm_monitor

// file: src/dsfm_pkg.sv
// types shared by the fault monitor
package dsfm_pkg;
  typedef logic [15:0] dsfm_err_t;
  typedef logic [2:0] dsfm_class_t;
endpackage : dsfm_pkg

// file: src/dsfm_sync.sv
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps
module dsfm_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  // first stage feeds only the second
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : dsfm_sync
